/* include/tcw_defines.vh */
// Register offsets, field positions, reset values and mode codes of the waveform timer
`ifndef TCW_DEFINES_VH
`define TCW_DEFINES_VH
`define TCW_ADDR_CTRL      4'h0
`define TCW_ADDR_COUNT     4'h1
`define TCW_ADDR_COMPARE   4'h2
`define TCW_ADDR_STATUS    4'h3
`define TCW_ADDR_DDR       4'h4
`define TCW_CTRL_WGM_LSB   0
`define TCW_CTRL_COM_LSB   2
`define TCW_CTRL_CS_LSB    4
`define TCW_CTRL_FOC_BIT   7
`define TCW_STAT_OVF_BIT   0
`define TCW_STAT_CMP_BIT   1
`define TCW_STAT_ACK_OVF   2
`define TCW_STAT_ACK_CMP   3
`define TCW_CTRL_RESET     8'h00
`define TCW_COUNT_RESET    8'h00
`define TCW_COMPARE_RESET  8'h00
`define TCW_WGM_NORMAL     2'h0
`define TCW_WGM_PCPWM      2'h1
`define TCW_WGM_CTC        2'h2
`define TCW_WGM_SPARE      2'h3
`define TCW_COM_NONE       2'h0
`define TCW_COM_TOGGLE     2'h1
`define TCW_COM_CLEAR      2'h2
`define TCW_COM_SET        2'h3
`define TCW_BOTTOM         8'h00
`define TCW_MAX            8'hFF
`define TCW_PRE_WIDTH      10
`endif

/* rtl/tcw_timer.v */
// Eight-bit timer/counter with one compare channel and waveform generator
// Operation
// - Output mode zero takes no action on the output at compare match.
// - New output mode takes effect only from the next compare match.
// - Force strobe in non-PWM modes applies the selected action immediately.
// - Only the waveform mode shapes counting; output mode never touches it.
// - Non-PWM: set, clear or toggle on match; PWM: inverted or not.
// - Waveform mode zero counts up only, wrapping from FF to 00.
// - Normal mode sets overflow flag as count becomes zero; never clears.
// - Overflow flag clears when the overflow interrupt is serviced.
// - Software may write the count at any time in normal mode.
// - Waveform mode two counts up to compare value then clears.
// - Phase-correct PWM sets the overflow flag at bottom.
// - Phase-correct PWM: output mode two non-inverted, three inverted.
// - Non-inverted: clear on up-match, set on down-match; inverted opposite.
// - Phase-correct period is 510 timer clocks, up to max then down.
// - Prescaler divides by 1, 8, 32, 64, 128, 256 or 1024.
// - Compare at bottom holds low, at max holds high, inverted opposite.
// - Compare output reaches the pin only when pin direction is output.
// - Status flags clear when software writes one to their bit.
//
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "tcw_defines.vh"

// Structure: a free-running prescaler offers one tick per selected divider, the
// counting process moves the count on each tick according to the waveform mode
// only, and a separate process decides the output level from matches and from
// the force strobe. Status flags are sticky and cleared by software or by an
// interrupt acknowledge; a hardware set in the same cycle as a clear wins, so
// an event is never lost.
// Limitation: the compare value takes effect at once, with no shadow copy, so
// moving it below the running count in clear-on-compare mode lets the count
// run on to the wrap before the next match.
// Changing the waveform mode on the fly keeps the current count and direction,
// which can give one irregular period before the new shape settles.
// The pin direction bit gates the level at the pin; the level itself keeps
// running while the pin is an input, so enabling the pin shows the live wave.
// The acknowledge inputs come from logic on this clock and need no synchroniser.

module tcw_timer (
	input  wire       mclk_in,
	input  wire       arst_n_in,
	input  wire [3:0] addr_in,
	input  wire [7:0] wdata_in,
	input  wire       wr_in,
	input  wire       rd_in,
	input  wire       ovf_ack_in,
	input  wire       cmp_ack_in,
	output reg  [7:0] rdata_out,
	output wire       compare_output_a_out,
	output wire       compare_output_a_oe_out,
	output wire       ovf_irq_out,
	output wire       cmp_irq_out
);
	// One-hot direction states for phase-correct counting
	localparam [1:0] ST_UP   = 2'b01;
	localparam [1:0] ST_DOWN = 2'b10;

	// Control fields and state; every one of them is reset, none starts unknown
	reg  [1:0]               waveform_mode_field_reg;
	reg  [1:0]               compare_output_mode_field_reg;
	reg  [2:0]               clk_sel_reg;
	reg                      ovf_ien_reg;
	reg                      cmp_ien_reg;
	reg  [7:0]               counter_value_reg;
	reg  [7:0]               counter_value_next;
	reg  [7:0]               compare_value_a_reg;
	reg                      overflow_flag_reg;
	reg                      compare_flag_reg;
	reg                      compare_output_a_reg;
	reg                      compare_output_a_next;
	reg                      pin_dir_reg;
	reg  [1:0]               dir_reg;
	reg  [1:0]               dir_next;
	reg  [`TCW_PRE_WIDTH-1:0] pre_reg;
	reg                      tick;
	reg                      ovf_set;
	reg                      cmp_set;
	wire                     wr_ctrl;
	wire                     wr_count;
	wire                     wr_stat;
	wire                     pwm_mode;
	wire                     force_strobe;
	wire                     match;
	// Modes carried by a control write, and one tick candidate per select
	wire [1:0]               force_mode;
	wire [1:0]               force_wave;
	wire [7:0]               tap_hit;

	// Register write decodes, PWM mode and compare match
	assign wr_ctrl  = wr_in && (addr_in == `TCW_ADDR_CTRL);
	assign wr_count = wr_in && (addr_in == `TCW_ADDR_COUNT);
	assign wr_stat  = wr_in && (addr_in == `TCW_ADDR_STATUS);
	assign pwm_mode = (waveform_mode_field_reg == `TCW_WGM_PCPWM);
	assign match    = (counter_value_reg == compare_value_a_reg);

	// The force strobe acts with the output mode of the very write that carries
	// it, so software picks an action and fires it in one access; a write that
	// selects phase-correct PWM cannot force anything
	assign force_mode   = wdata_in[`TCW_CTRL_COM_LSB +: 2];
	assign force_wave   = wdata_in[`TCW_CTRL_WGM_LSB +: 2];
	assign force_strobe = wr_ctrl && wdata_in[`TCW_CTRL_FOC_BIT] &&
		(force_wave != `TCW_WGM_PCPWM);

	// Low prescaler bits that must all be one before a divider ticks
	function [3:0] tcw_span;
		input integer sel;
		begin
			case (sel)
				1:       tcw_span = 4'h0;
				2:       tcw_span = 4'h3;
				3:       tcw_span = 4'h5;
				4:       tcw_span = 4'h6;
				5:       tcw_span = 4'h7;
				6:       tcw_span = 4'h8;
				7:       tcw_span = 4'hA;
				default: tcw_span = 4'h0;
			endcase
		end
	endfunction

	// Non-PWM action on the output level, shared by the match and force paths
	function tcw_action;
		input [1:0] mode;
		input       level;
		begin
			case (mode)
				`TCW_COM_TOGGLE: tcw_action = ~level;
				`TCW_COM_CLEAR:  tcw_action = 1'b0;
				`TCW_COM_SET:    tcw_action = 1'b1;
				default:         tcw_action = level;
			endcase
		end
	endfunction

	// One tap per select; select zero has no tap, which stops the counter while
	// the prescaler keeps running, so a later start meets the same tap phase
	assign tap_hit[0] = 1'b0;
	genvar gi;
	generate
		for (gi = 1; gi < 8; gi = gi + 1) begin : g_tap
			// All bits under the mask at one marks the last cycle of a divider period
			wire [`TCW_PRE_WIDTH-1:0] span_mask;
			assign span_mask   = ~({`TCW_PRE_WIDTH{1'b1}} << tcw_span(gi));
			assign tap_hit[gi] = ((pre_reg & span_mask) == span_mask);
		end
	endgenerate

	// Prescaler runs always so the taps stay aligned; it is never cleared on a
	// select change, trading an exact first period for a simpler divider
	// that cannot glitch when software switches the rate
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_reg <= {`TCW_PRE_WIDTH{1'b0}};
		end else begin
			pre_reg <= pre_reg + 10'h001;
		end
	end

	// Tick of the chosen divider; one cycle wide, or high every cycle at divide by 1,
	// so each cycle of it moves the count exactly once
	always @* begin
		tick = tap_hit[clk_sel_reg];
	end

	// Counting sequence; only the waveform mode is looked at here
	// A count write beats the tick in the same cycle, so software reads back
	// exactly the value it wrote
	always @* begin
		counter_value_next = counter_value_reg;
		dir_next = dir_reg;
		ovf_set = 1'b0;
		cmp_set = 1'b0;
		if (tick) begin
			cmp_set = match;
			case (waveform_mode_field_reg)
				`TCW_WGM_PCPWM: begin
					// Reverse at the ends: 255 steps up, 255 down makes 510
					case (dir_reg)
						ST_UP: begin
							if (counter_value_reg == `TCW_MAX) begin
								counter_value_next = counter_value_reg - 8'h01;
								dir_next = ST_DOWN;
							end else begin
								counter_value_next = counter_value_reg + 8'h01;
							end
						end
						ST_DOWN: begin
							if (counter_value_reg == `TCW_BOTTOM) begin
								counter_value_next = counter_value_reg + 8'h01;
								dir_next = ST_UP;
							end else begin
								counter_value_next = counter_value_reg - 8'h01;
								ovf_set = (counter_value_reg == 8'h01);
							end
						end
						default: begin
							dir_next = ST_UP;
						end
					endcase
				end
				`TCW_WGM_CTC: begin
					if (match) begin
						counter_value_next = `TCW_BOTTOM;
					end else begin
						counter_value_next = counter_value_reg + 8'h01;
					end
					ovf_set = (counter_value_reg == `TCW_MAX);
				end
				default: begin
					counter_value_next = counter_value_reg + 8'h01;
					ovf_set = (counter_value_reg == `TCW_MAX);
				end
			endcase
		end
		if (wr_count) begin
			counter_value_next = wdata_in;
		end
	end

	// Output action; the mode is sampled only when a match or force happens
	// The level lives in its own register so that a mode write alone never
	// disturbs the wave already on the pin
	always @* begin
		compare_output_a_next = compare_output_a_reg;
		if (pwm_mode) begin
			if (tick && match) begin
				case (compare_output_mode_field_reg)
					`TCW_COM_CLEAR: begin
						// Up-match clears, down-match sets; extremes hold a level
						compare_output_a_next = (dir_reg == ST_DOWN);
						if (compare_value_a_reg == `TCW_BOTTOM) compare_output_a_next = 1'b0;
						if (compare_value_a_reg == `TCW_MAX) compare_output_a_next = 1'b1;
					end
					`TCW_COM_SET: begin
						compare_output_a_next = (dir_reg == ST_UP);
						if (compare_value_a_reg == `TCW_BOTTOM) compare_output_a_next = 1'b1;
						if (compare_value_a_reg == `TCW_MAX) compare_output_a_next = 1'b0;
					end
					default: begin
						compare_output_a_next = compare_output_a_reg;
					end
				endcase
			end
		end else if (force_strobe) begin
			// A force beats a match in the same cycle, being the newer request
			compare_output_a_next = tcw_action(force_mode, compare_output_a_reg);
		end else if (tick && match) begin
			// The stored mode is read only at a match, here or in the PWM branch, so a mode write waits for a match
			compare_output_a_next = tcw_action(compare_output_mode_field_reg,
				compare_output_a_reg);
		end
	end

	// State registers; an output-mode write changes nothing until the next match
	// The direction state is kept across mode changes; it only matters in
	// phase-correct mode and is put right at the next end of the count
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			waveform_mode_field_reg       <= `TCW_WGM_NORMAL;
			compare_output_mode_field_reg <= `TCW_COM_NONE;
			clk_sel_reg                   <= 3'h0;
			ovf_ien_reg                   <= 1'b0;
			cmp_ien_reg                   <= 1'b0;
			counter_value_reg             <= `TCW_COUNT_RESET;
			compare_value_a_reg           <= `TCW_COMPARE_RESET;
			compare_output_a_reg          <= 1'b0;
			pin_dir_reg                   <= 1'b0;
			dir_reg                       <= ST_UP;
		end else begin
			counter_value_reg    <= counter_value_next;
			dir_reg              <= dir_next;
			compare_output_a_reg <= compare_output_a_next;
			if (wr_ctrl) begin
				waveform_mode_field_reg       <= wdata_in[`TCW_CTRL_WGM_LSB +: 2];
				compare_output_mode_field_reg <= wdata_in[`TCW_CTRL_COM_LSB +: 2];
				clk_sel_reg                   <= wdata_in[`TCW_CTRL_CS_LSB +: 3];
			end
			if (wr_in && (addr_in == `TCW_ADDR_COMPARE)) begin
				compare_value_a_reg <= wdata_in;
			end
			if (wr_in && (addr_in == `TCW_ADDR_DDR)) begin
				pin_dir_reg <= wdata_in[0];
				ovf_ien_reg <= wdata_in[1];
				cmp_ien_reg <= wdata_in[2];
			end
		end
	end

	// Sticky flags: hardware set wins over a clear in the same cycle
	// Losing a clear costs software one more service; losing a set would hide
	// an event for a whole period
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			overflow_flag_reg <= 1'b0;
			compare_flag_reg  <= 1'b0;
		end else begin
			if (ovf_set) begin
				overflow_flag_reg <= 1'b1;
			end else if ((wr_stat && wdata_in[`TCW_STAT_OVF_BIT]) || ovf_ack_in) begin
				overflow_flag_reg <= 1'b0;
			end
			if (cmp_set) begin
				compare_flag_reg <= 1'b1;
			end else if ((wr_stat && wdata_in[`TCW_STAT_CMP_BIT]) || cmp_ack_in) begin
				compare_flag_reg <= 1'b0;
			end
		end
	end

	// Read data stands in the cycle after the strobe only
	// Returning zero outside reads keeps a shared read bus free of stale data
	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				`TCW_ADDR_CTRL:    rdata_out <= {1'b0, clk_sel_reg,
					compare_output_mode_field_reg, waveform_mode_field_reg};
				`TCW_ADDR_COUNT:   rdata_out <= counter_value_reg;
				`TCW_ADDR_COMPARE: rdata_out <= compare_value_a_reg;
				`TCW_ADDR_STATUS:  rdata_out <= {5'h00, compare_output_a_reg,
					compare_flag_reg, overflow_flag_reg};
				`TCW_ADDR_DDR:     rdata_out <= {5'h00, cmp_ien_reg, ovf_ien_reg, pin_dir_reg};
				default:           rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// Pin is driven only when its direction is output
	// The level is masked as well, so an input pin never shows a stale high
	// Interrupt requests are plain levels of flag and enable
	assign compare_output_a_out    = compare_output_a_reg & pin_dir_reg;
	assign compare_output_a_oe_out = pin_dir_reg;
	assign ovf_irq_out = overflow_flag_reg & ovf_ien_reg;
	assign cmp_irq_out = compare_flag_reg & cmp_ien_reg;
endmodule
`default_nettype wire

/* dv/tcw_timer_asserts.sv */
// Port-level assertions of the waveform timer
`timescale 1ns/1ns
`default_nettype none
module tcw_timer_chk (
	input wire logic       mclk_in,
	input wire logic       arst_n_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic       ovf_ack_in,
	input wire logic       cmp_ack_in,
	input wire logic [7:0] rdata_out,
	input wire logic       compare_output_a_out,
	input wire logic       compare_output_a_oe_out,
	input wire logic       ovf_irq_out,
	input wire logic       cmp_irq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	// Status reads, two steps each
	sequence stat_rd_s;
		rd_in && addr_in == 4'h3 ##1 1'b1;
	endsequence
	sequence ovf_low_s;
		rd_in && addr_in == 4'h3 ##1 !rdata_out[0];
	endsequence
	// Read data stands only in the cycle after a read
	chk_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data outside read");
	chk_unmapped_read: assert property (rd_in && addr_in > 4'h4 |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
	// Pin follows the level only while driven
	chk_pin_gated: assert property (!compare_output_a_oe_out |-> !compare_output_a_out)
		else $error("pin driven while input");
	chk_dir_write: assert property (wr_in && addr_in == 4'h4
		|=> compare_output_a_oe_out == $past(wdata_in[0]))
		else $error("direction write lost");
	chk_dir_read: assert property (rd_in && addr_in == 4'h4
		|=> rdata_out[0] == $past(compare_output_a_oe_out))
		else $error("direction readback wrong");
	chk_level_read: assert property (stat_rd_s
		|-> (rdata_out[2] & $past(compare_output_a_oe_out)) == $past(compare_output_a_out))
		else $error("level and pin disagree");
	// A clear flag or a cleared enable silences the interrupt
	chk_ovf_quiet: assert property (ovf_low_s |-> !$past(ovf_irq_out))
		else $error("overflow irq without flag");
	chk_cmp_mask: assert property (wr_in && addr_in == 4'h4 && !wdata_in[2] |=> !cmp_irq_out)
		else $error("compare irq while masked");
endmodule
bind tcw_timer tcw_timer_chk u_chk (.mclk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in,
	.rd_in, .ovf_ack_in, .cmp_ack_in, .rdata_out, .compare_output_a_out,
	.compare_output_a_oe_out, .ovf_irq_out, .cmp_irq_out);
`default_nettype wire

/* dv/tcw_timer_test.sv */
// Self-checking bench of the waveform timer
`timescale 1ns/1ns
`default_nettype none
module tcw_timer_test;
	logic        mclk_in, arst_n_in, wr_in, rd_in, ovf_ack_in, cmp_ack_in;
	logic [3:0]  addr_in;
	logic [7:0]  wdata_in, rdata_out, v;
	logic [1:0]  c;
	logic        pin, oe, ovf_irq, cmp_irq, rd_d, e;
	logic [15:0] q[$], n;
	int          miscompares, comparisons, cyc, hi, h, seed, i, j;
	int          f[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	tcw_timer uut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .ovf_ack_in(ovf_ack_in),
		.cmp_ack_in(cmp_ack_in), .rdata_out(rdata_out), .compare_output_a_out(pin),
		.compare_output_a_oe_out(oe), .ovf_irq_out(ovf_irq), .cmp_irq_out(cmp_irq));
	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus cycle, then a quiet cycle so strobes never get two drives at once
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= w;
		rd_in <= !w;
		@(posedge mclk_in) wr_in <= 1'b0;
		rd_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
		q.push_back({m, x});
		acc(1'b0, a, 8'h00);
	endtask
	task automatic run(input logic [7:0] ctl, input int k);
		acc(1'b1, 4'h0, ctl);
		repeat (k) @(posedge mclk_in);
		acc(1'b1, 4'h0, ctl & 8'h0F);
	endtask
	task automatic summarize;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Read results are matched against the oldest note
	always @(posedge mclk_in) begin
		if (rd_d) begin
			n = q.pop_front();
			chk(16'(rdata_out & n[15:8]), 16'(n[7:0]));
		end
		rd_d <= rd_in;
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		seed = 10;
		{arst_n_in, wr_in, rd_in, ovf_ack_in, cmp_ack_in, addr_in, wdata_in, rd_d} = '0;
		repeat (3) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		@(posedge mclk_in);
		// Reset values, an unmapped place, random counts while stopped
		for (i = 0; i < 5; i++)
			rd(i[3:0], 8'hFF, 8'h00);
		acc(1'b1, 4'h9, 8'hFF);
		rd(4'h9, 8'hFF, 8'h00);
		for (i = 0; i < 4; i++) begin
			v = 8'($random(seed));
			acc(1'b1, 4'h1, v);
			rd(4'h1, 8'hFF, v);
		end
		// Normal mode wraps and ignores the compare; flags cleared two ways
		acc(1'b1, 4'h4, 8'h06);
		acc(1'b1, 4'h2, 8'h05);
		for (j = 0; j < 2; j++) begin
			acc(1'b1, 4'h1, 8'hFE);
			run(8'h10, 11);
			rd(4'h1, 8'hF8, 8'h08);
			rd(4'h3, 8'h03, 8'h03);
			chk(16'(ovf_irq & cmp_irq), 16'h0001);
			ovf_ack_in <= (j == 0);
			cmp_ack_in <= (j == 0);
			@(posedge mclk_in) ovf_ack_in <= 1'b0;
			cmp_ack_in <= 1'b0;
			if (j == 1)
				acc(1'b1, 4'h3, 8'h03);
			rd(4'h3, 8'h03, 8'h00);
		end
		// Forced actions on a stopped timer: set, clear, toggle, none, toggle
		acc(1'b1, 4'h4, 8'h01);
		e = 1'b0;
		for (i = 0; i < 5; i++) begin
			c = (i == 4) ? 2'h1 : 2'(3 - i);
			acc(1'b1, 4'h0, {4'h8, c, 2'h0});
			e = (c == 2'h3) ? 1'b1 : (c == 2'h2) ? 1'b0 : e ^ (c == 2'h1);
			chk(16'(pin), 16'(e));
			rd(4'h3, 8'h04, {5'h0, e, 2'h0});
		end
		acc(1'b1, 4'h0, 8'h0C);
		rd(4'h3, 8'h04, 8'h00);
		acc(1'b1, 4'h4, 8'h00);
		chk(16'(pin), 16'h0000);
		// Clear on compare keeps the count at or under the compare value
		acc(1'b1, 4'h2, 8'h03);
		for (i = 0; i < 4; i++) begin
			acc(1'b1, 4'h1, 8'h00);
			run({4'h1, i[1:0], 2'h2}, 40);
			rd(4'h1, 8'hFC, 8'h00);
		end
		// Free-running prescaler gives four or five ticks in 4.5 periods
		for (i = 2; i < 8; i++) begin
			acc(1'b1, 4'h1, 8'h00);
			run({1'b0, i[2:0], 4'h0}, f[i] * 9 / 2 - 2);
			rd(4'h1, 8'hFE, 8'h04);
		end
		// Phase-correct high time over one whole period, both polarities
		acc(1'b1, 4'h4, 8'h01);
		acc(1'b1, 4'h3, 8'h03);
		for (i = 0; i < 6; i++) begin
			v = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'hFF : 8'h80;
			h = (v == 8'h00) ? 0 : (v == 8'hFF) ? 510 : 256;
			h = (i > 2) ? 510 - h : h;
			acc(1'b1, 4'h2, v);
			acc(1'b1, 4'h0, {4'h1, 2'(2 + i / 3), 2'h1});
			repeat (520) @(posedge mclk_in);
			hi = 0;
			repeat (510) @(posedge mclk_in) hi += pin;
			chk(16'(hi), 16'(h));
		end
		rd(4'h3, 8'h01, 8'h01);
		repeat (2) @(posedge mclk_in);
		summarize();
	end
endmodule
`default_nettype wire
